// *** hdl/pcv_pkg.sv ***
// Constants and types shared by the program counter vectoring block
package pcv_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned PCV_PC_W = 10;
  localparam int unsigned PCV_BYTE_W = 8;
  localparam int unsigned PCV_WORD_W = 16;
  localparam int unsigned PCV_CTX_FLAG_W = 6;

  // ----------------------------------------------------------------
  // Program addresses
  // ----------------------------------------------------------------
  localparam logic [9:0] PCV_RESET_VECTOR = 10'h000;
  localparam logic [9:0] PCV_IRQ_VECTOR = 10'h008;
  localparam logic [9:0] PCV_RSV_FIRST = 10'h3FD;
  localparam logic [9:0] PCV_RSV_LAST = 10'h3FF;
  localparam logic [9:0] PCV_PC_STEP = 10'h001;

  // ----------------------------------------------------------------
  // Special flag register fields
  // ----------------------------------------------------------------
  localparam int unsigned PCV_FLAG_A_BIT = 7;
  localparam int unsigned PCV_FLAG_B_BIT = 6;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic PCV_POR_FLAG_A = 1'b1;
  localparam logic PCV_POR_FLAG_B = 1'b0;
  localparam logic PCV_WDT_FLAG_A = 1'b0;
  localparam logic PCV_WDT_FLAG_B = 1'b0;
  localparam logic PCV_EXT_FLAG_A = 1'b1;
  localparam logic PCV_EXT_FLAG_B = 1'b1;
  localparam logic [7:0] PCV_BYTE_RESET = 8'h00;
  localparam logic [5:0] PCV_CTX_FLAG_RESET = 6'h00;
  localparam logic [15:0] PCV_WORD_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Table read sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PCV_TBL_IDLE = 2'h0,
    PCV_TBL_ISSUE = 2'h1,
    PCV_TBL_CAPTURE = 2'h2
  } pcv_tbl_state_t;

endpackage

// *** hdl/pcv_reset_cause.sv ***
// Reset cause flags and system soft reset pulse
`timescale 1ns/1ps
`default_nettype none

module pcv_reset_cause (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wdt_reset_req,
  input wire logic ext_reset_req,
  output logic reset_cause_flag_a,
  output logic reset_cause_flag_b,
  output logic soft_rst
);

  logic flag_a_q;
  logic flag_a_d;
  logic flag_b_q;
  logic flag_b_d;
  logic soft_q;
  logic soft_d;

  // ----------------------------------------------------------------
  // Cause capture; external wins when both arrive together
  // ----------------------------------------------------------------
  always_comb
  begin
    flag_a_d = flag_a_q;
    flag_b_d = flag_b_q;
    soft_d = 1'b0;
    if (ext_reset_req)
    begin
      flag_a_d = pcv_pkg::PCV_EXT_FLAG_A;
      flag_b_d = pcv_pkg::PCV_EXT_FLAG_B;
      soft_d = 1'b1;
    end
    else if (wdt_reset_req)
    begin
      flag_a_d = pcv_pkg::PCV_WDT_FLAG_A;
      flag_b_d = pcv_pkg::PCV_WDT_FLAG_B;
      soft_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_a_q <= pcv_pkg::PCV_POR_FLAG_A;
      flag_b_q <= pcv_pkg::PCV_POR_FLAG_B;
      soft_q <= 1'b0;
    end
    else
    begin
      flag_a_q <= flag_a_d;
      flag_b_q <= flag_b_d;
      soft_q <= soft_d;
    end
  end

  assign reset_cause_flag_a = flag_a_q;
  assign reset_cause_flag_b = flag_b_q;
  assign soft_rst = soft_q;

endmodule

`default_nettype wire

// *** hdl/pcv_ctx_buffer.sv ***
// Single-level context save and restore buffer
`timescale 1ns/1ps
`default_nettype none

module pcv_ctx_buffer (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic soft_rst,
  input wire logic ctx_save,
  input wire logic ctx_restore,
  input wire logic [7:0] accumulator,
  input wire logic [7:0] special_flag_register,
  output logic [7:0] ctx_acc,
  output logic [5:0] ctx_flags,
  output logic ctx_restore_valid
);

  logic [7:0] acc_q;
  logic [7:0] acc_d;
  logic [5:0] flg_q;
  logic [5:0] flg_d;
  logic vld_q;
  logic vld_d;

  // ----------------------------------------------------------------
  // One slot only, a new save replaces the old one
  // ----------------------------------------------------------------
  always_comb
  begin
    acc_d = acc_q;
    flg_d = flg_q;
    vld_d = 1'b0;
    if (soft_rst)
    begin
      acc_d = pcv_pkg::PCV_BYTE_RESET;
      flg_d = pcv_pkg::PCV_CTX_FLAG_RESET;
    end
    else if (ctx_save)
    begin
      acc_d = accumulator;
      flg_d = special_flag_register[5:0];
    end
    else if (ctx_restore)
    begin
      vld_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_q <= pcv_pkg::PCV_BYTE_RESET;
      flg_q <= pcv_pkg::PCV_CTX_FLAG_RESET;
      vld_q <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      flg_q <= flg_d;
      vld_q <= vld_d;
    end
  end

  assign ctx_acc = acc_q;
  assign ctx_flags = flg_q;
  assign ctx_restore_valid = vld_q;

endmodule

`default_nettype wire

// *** hdl/pcv_top.sv ***
// Program counter, vectoring, context buffer and table read sequencing
`timescale 1ns/1ps
`default_nettype none

module pcv_top (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic wdt_reset_req,
  input wire logic ext_reset_req,
  input wire logic pc_step,
  input wire logic pc_jump,
  input wire logic [9:0] pc_jump_target,
  input wire logic irq_take,
  input wire logic interrupt_return,
  input wire logic [9:0] return_addr,
  input wire logic bank_zero_add,
  input wire logic pcl_sub,
  input wire logic [7:0] accumulator,
  input wire logic [7:0] special_flag_register,
  input wire logic ctx_save,
  input wire logic ctx_restore,
  input wire logic idx_high_wr,
  input wire logic idx_low_wr,
  input wire logic [7:0] idx_wdata,
  input wire logic idx_low_inc,
  input wire logic idx_high_inc,
  input wire logic rom_table_read,
  input wire logic [15:0] rom_data,
  output logic [9:0] fetch_addr,
  output logic [7:0] pc_low_byte,
  output logic [1:0] pc_high_part,
  output logic pc_in_reserved,
  output logic push_valid,
  output logic [9:0] push_addr,
  output logic reset_cause_flag_a,
  output logic reset_cause_flag_b,
  output logic [7:0] ctx_acc,
  output logic [5:0] ctx_flags,
  output logic ctx_restore_valid,
  output logic [7:0] idx_high,
  output logic [7:0] idx_low,
  output logic rom_rd_en,
  output logic [15:0] rom_addr,
  output logic tbl_busy,
  output logic tbl_done,
  output logic [7:0] tbl_acc_data,
  output logic [7:0] lookup_result
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;
  logic soft_rst;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  pcv_reset_cause u_cause (
    .clk_sys(clk_sys),
    .rst_n(rst_sync_q),
    .wdt_reset_req(wdt_reset_req),
    .ext_reset_req(ext_reset_req),
    .reset_cause_flag_a(reset_cause_flag_a),
    .reset_cause_flag_b(reset_cause_flag_b),
    .soft_rst(soft_rst)
  );

  pcv_ctx_buffer u_ctx (
    .clk_sys(clk_sys),
    .rst_n(rst_sync_q),
    .soft_rst(soft_rst),
    .ctx_save(ctx_save),
    .ctx_restore(ctx_restore),
    .accumulator(accumulator),
    .special_flag_register(special_flag_register),
    .ctx_acc(ctx_acc),
    .ctx_flags(ctx_flags),
    .ctx_restore_valid(ctx_restore_valid)
  );

  // ----------------------------------------------------------------
  // PC arithmetic
  // ----------------------------------------------------------------
  function automatic logic [9:0] pcv_low_add(input logic [9:0] pc, input logic [7:0] a);
    logic [8:0] sum;
    sum = {1'b0, pc[7:0]} + {1'b0, a};
    return {pc[9:8] + {1'b0, sum[8]}, sum[7:0]};
  endfunction

  function automatic logic [9:0] pcv_low_sub(input logic [9:0] pc, input logic [7:0] a);
    logic [7:0] dif;
    dif = pc[7:0] - a;
    return {pc[9:8], dif};
  endfunction

  // ----------------------------------------------------------------
  // Program counter and interrupt push
  // ----------------------------------------------------------------
  logic [9:0] pc_q;
  logic [9:0] pc_d;
  logic push_vld_q;
  logic push_vld_d;
  logic [9:0] push_addr_q;
  logic [9:0] push_addr_d;

  always_comb
  begin
    pc_d = pc_q;
    push_vld_d = 1'b0;
    push_addr_d = push_addr_q;
    if (soft_rst)
    begin
      pc_d = pcv_pkg::PCV_RESET_VECTOR;
      push_addr_d = pcv_pkg::PCV_RESET_VECTOR;
    end
    else if (irq_take)
    begin
      push_vld_d = 1'b1;
      push_addr_d = pc_q;
      pc_d = pcv_pkg::PCV_IRQ_VECTOR;
    end
    else if (interrupt_return)
    begin
      pc_d = return_addr;
    end
    else if (pc_jump)
    begin
      pc_d = pc_jump_target;
    end
    else if (bank_zero_add)
    begin
      pc_d = pcv_low_add(pc_q, accumulator);
    end
    else if (pcl_sub)
    begin
      pc_d = pcv_low_sub(pc_q, accumulator);
    end
    else if (pc_step)
    begin
      pc_d = pc_q + pcv_pkg::PCV_PC_STEP;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      pc_q <= pcv_pkg::PCV_RESET_VECTOR;
      push_vld_q <= 1'b0;
      push_addr_q <= pcv_pkg::PCV_RESET_VECTOR;
    end
    else
    begin
      pc_q <= pc_d;
      push_vld_q <= push_vld_d;
      push_addr_q <= push_addr_d;
    end
  end

  assign fetch_addr = pc_q;
  assign pc_low_byte = pc_q[7:0];
  assign pc_high_part = pc_q[9:8];
  assign pc_in_reserved = (pc_q >= pcv_pkg::PCV_RSV_FIRST) && (pc_q <= pcv_pkg::PCV_RSV_LAST);
  assign push_valid = push_vld_q;
  assign push_addr = push_addr_q;

  // ----------------------------------------------------------------
  // Table index registers
  // ----------------------------------------------------------------
  logic [7:0] idx_hi_q;
  logic [7:0] idx_hi_d;
  logic [7:0] idx_lo_q;
  logic [7:0] idx_lo_d;

  always_comb
  begin
    idx_hi_d = idx_hi_q;
    idx_lo_d = idx_lo_q;
    if (soft_rst)
    begin
      idx_hi_d = pcv_pkg::PCV_BYTE_RESET;
      idx_lo_d = pcv_pkg::PCV_BYTE_RESET;
    end
    else
    begin
      if (idx_high_wr)
      begin
        idx_hi_d = idx_wdata;
      end
      else if (idx_high_inc)
      begin
        idx_hi_d = idx_hi_q + 8'h01;
      end
      if (idx_low_wr)
      begin
        idx_lo_d = idx_wdata;
      end
      else if (idx_low_inc)
      begin
        idx_lo_d = idx_lo_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      idx_hi_q <= pcv_pkg::PCV_BYTE_RESET;
      idx_lo_q <= pcv_pkg::PCV_BYTE_RESET;
    end
    else
    begin
      idx_hi_q <= idx_hi_d;
      idx_lo_q <= idx_lo_d;
    end
  end

  assign idx_high = idx_hi_q;
  assign idx_low = idx_lo_q;

  // ----------------------------------------------------------------
  // Table read sequencer
  // ----------------------------------------------------------------
  pcv_pkg::pcv_tbl_state_t tbl_q;
  pcv_pkg::pcv_tbl_state_t tbl_d;
  logic [15:0] raddr_q;
  logic [15:0] raddr_d;
  logic done_q;
  logic done_d;
  logic [7:0] tacc_q;
  logic [7:0] tacc_d;
  logic [7:0] res_q;
  logic [7:0] res_d;

  always_comb
  begin
    tbl_d = tbl_q;
    raddr_d = raddr_q;
    done_d = 1'b0;
    tacc_d = tacc_q;
    res_d = res_q;
    if (soft_rst)
    begin
      tbl_d = pcv_pkg::PCV_TBL_IDLE;
      raddr_d = pcv_pkg::PCV_WORD_RESET;
      tacc_d = pcv_pkg::PCV_BYTE_RESET;
      res_d = pcv_pkg::PCV_BYTE_RESET;
    end
    else
    begin
      unique case (tbl_q)
        pcv_pkg::PCV_TBL_IDLE:
        begin
          if (rom_table_read)
          begin
            raddr_d = {idx_hi_q, idx_lo_q};
            tbl_d = pcv_pkg::PCV_TBL_ISSUE;
          end
        end
        pcv_pkg::PCV_TBL_ISSUE:
        begin
          tbl_d = pcv_pkg::PCV_TBL_CAPTURE;
        end
        pcv_pkg::PCV_TBL_CAPTURE:
        begin
          tacc_d = rom_data[7:0];
          res_d = rom_data[15:8];
          done_d = 1'b1;
          tbl_d = pcv_pkg::PCV_TBL_IDLE;
        end
        default:
        begin
          tbl_d = pcv_pkg::PCV_TBL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      tbl_q <= pcv_pkg::PCV_TBL_IDLE;
      raddr_q <= pcv_pkg::PCV_WORD_RESET;
      done_q <= 1'b0;
      tacc_q <= pcv_pkg::PCV_BYTE_RESET;
      res_q <= pcv_pkg::PCV_BYTE_RESET;
    end
    else
    begin
      tbl_q <= tbl_d;
      raddr_q <= raddr_d;
      done_q <= done_d;
      tacc_q <= tacc_d;
      res_q <= res_d;
    end
  end

  assign rom_rd_en = (tbl_q == pcv_pkg::PCV_TBL_ISSUE);
  assign rom_addr = raddr_q;
  assign tbl_busy = (tbl_q != pcv_pkg::PCV_TBL_IDLE);
  assign tbl_done = done_q;
  assign tbl_acc_data = tacc_q;
  assign lookup_result = res_q;

endmodule

`default_nettype wire

// *** tb/pcv_chk.sv ***
// Concurrent checks on the program counter vectoring block ports
`timescale 1ns/1ps
`default_nettype none

module pcv_chk (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic wdt_reset_req,
  input wire logic ext_reset_req,
  input wire logic pc_jump,
  input wire logic irq_take,
  input wire logic interrupt_return,
  input wire logic bank_zero_add,
  input wire logic pcl_sub,
  input wire logic [7:0] accumulator,
  input wire logic [7:0] special_flag_register,
  input wire logic ctx_save,
  input wire logic ctx_restore,
  input wire logic idx_high_wr,
  input wire logic idx_low_wr,
  input wire logic idx_low_inc,
  input wire logic idx_high_inc,
  input wire logic rom_table_read,
  input wire logic [15:0] rom_data,
  input wire logic [9:0] fetch_addr,
  input wire logic [7:0] pc_low_byte,
  input wire logic [1:0] pc_high_part,
  input wire logic pc_in_reserved,
  input wire logic push_valid,
  input wire logic [9:0] push_addr,
  input wire logic reset_cause_flag_a,
  input wire logic reset_cause_flag_b,
  input wire logic [7:0] ctx_acc,
  input wire logic [5:0] ctx_flags,
  input wire logic ctx_restore_valid,
  input wire logic [7:0] idx_high,
  input wire logic [7:0] idx_low,
  input wire logic rom_rd_en,
  input wire logic [15:0] rom_addr,
  input wire logic tbl_busy,
  input wire logic tbl_done,
  input wire logic [7:0] tbl_acc_data,
  input wire logic [7:0] lookup_result
);
  // ----------------------------------------------------------------
  // Soft reset shadow, strobes near it may be dropped
  // ----------------------------------------------------------------
  logic req1_q;
  logic req2_q;
  logic ok;
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      req1_q <= 1'b0;
      req2_q <= 1'b0;
    end
    else
    begin
      req1_q <= wdt_reset_req | ext_reset_req;
      req2_q <= req1_q;
    end
  assign ok = !(req1_q | req2_q);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_irq_vector:
  assert property (irq_take && ok |=> fetch_addr == 10'h008 && push_valid
    && push_addr == $past(fetch_addr)) else $error("interrupt entry wrong");
  a_add_carry:
  assert property (bank_zero_add && ok && !(irq_take | interrupt_return | pc_jump)
    |=> fetch_addr == $past(fetch_addr) + {2'h0, $past(accumulator)})
    else $error("jump table add wrong");
  a_sub_keep_high:
  assert property (pcl_sub && ok && !(irq_take | interrupt_return | pc_jump | bank_zero_add)
    |=> pc_high_part == $past(pc_high_part)
    && pc_low_byte == $past(pc_low_byte) - $past(accumulator)) else $error("subtract wrong");
  a_ctx_copy:
  assert property (ctx_save && ok |=> ctx_acc == $past(accumulator)
    && {2'h0, ctx_flags} == ($past(special_flag_register) & 8'h3F))
    else $error("context save wrong");
  a_restore_pulse:
  assert property (ctx_restore && !ctx_save && ok |=> ctx_restore_valid)
    else $error("restore not flagged");
  a_idx_no_carry:
  assert property (idx_low_inc && ok && !idx_low_wr && !idx_high_wr && !idx_high_inc
    |=> idx_high == $past(idx_high) && idx_low == $past(idx_low) + 8'h01)
    else $error("index increment wrong");
  a_tbl_addr:
  assert property (rom_table_read && !tbl_busy && ok |=> rom_rd_en
    && rom_addr == {$past(idx_high), $past(idx_low)} ##2 tbl_done)
    else $error("table address or timing wrong");
  a_tbl_data:
  assert property (tbl_done |-> {lookup_result, tbl_acc_data} == $past(rom_data))
    else $error("table data wrong");
  a_reserved_flag:
  assert property (pc_in_reserved == (fetch_addr >= 10'h3FD))
    else $error("reserved flag wrong");
  a_ext_cause:
  assert property (ext_reset_req && ok |=> reset_cause_flag_a && reset_cause_flag_b
    ##1 fetch_addr == 10'h000) else $error("external reset wrong");
  a_wdt_cause:
  assert property (wdt_reset_req && !ext_reset_req && ok |=> !reset_cause_flag_a
    && !reset_cause_flag_b ##1 fetch_addr == 10'h000) else $error("watchdog reset wrong");

  c_irq: cover property (irq_take ##1 push_valid);
  c_tbl: cover property (rom_table_read ##3 tbl_done);
  c_ext: cover property (ext_reset_req);
endmodule

bind pcv_top pcv_chk u_chk (.*);

`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the program counter vectoring block
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam int STEP = 0, JMP = 1, IRQ = 2, RET = 3, ADD = 4, SUB = 5, SAV = 6, RES = 7;
  localparam int HWR = 8, LWR = 9, LINC = 10, HINC = 11, TRD = 12, WDT = 13, EXT = 14;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [14:0] stb = 15'h0000;
  logic [9:0] pc_jump_target = 10'h000;
  logic [9:0] return_addr = 10'h000;
  logic [7:0] accumulator = 8'h00;
  logic [7:0] special_flag_register = 8'h00;
  logic [7:0] idx_wdata = 8'h00;
  logic [15:0] rom_data = 16'h0000;
  wire logic pc_step, pc_jump, irq_take, interrupt_return, bank_zero_add, pcl_sub;
  wire logic ctx_save, ctx_restore, idx_high_wr, idx_low_wr, idx_low_inc, idx_high_inc;
  wire logic rom_table_read, wdt_reset_req, ext_reset_req;
  logic [9:0] fetch_addr, push_addr;
  logic [7:0] pc_low_byte, ctx_acc, idx_high, idx_low, tbl_acc_data, lookup_result;
  logic [1:0] pc_high_part;
  logic [5:0] ctx_flags;
  logic [15:0] rom_addr;
  logic pc_in_reserved, push_valid, reset_cause_flag_a, reset_cause_flag_b;
  logic ctx_restore_valid, rom_rd_en, tbl_busy, tbl_done;
  int err_count = 0;
  int compares = 0;
  int n;

  assign {ext_reset_req, wdt_reset_req, rom_table_read, idx_high_inc, idx_low_inc,
    idx_low_wr, idx_high_wr, ctx_restore, ctx_save, pcl_sub, bank_zero_add,
    interrupt_return, irq_take, pc_jump, pc_step} = stb;

  pcv_top u_dut (.*);

  always #2.5 clk_sys = ~clk_sys;

  // Program memory, one cycle behind the read enable
  always @(posedge clk_sys)
    if (rom_rd_en === 1'b1)
      rom_data <= (rom_addr === 16'h1200) ? 16'h5105 : 16'h2012;
    else
      rom_data <= ~rom_data;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic fire(input int k, input logic [9:0] a10, input logic [7:0] a8,
    input logic [7:0] f8);
    @(posedge clk_sys);
    stb <= 15'h0001 << k;
    pc_jump_target <= a10;
    return_addr <= a10;
    accumulator <= a8;
    idx_wdata <= a8;
    special_flag_register <= f8;
    @(posedge clk_sys);
    stb <= 15'h0000;
    @(negedge clk_sys);
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(fetch_addr, 16'h0000);
    chk({reset_cause_flag_a, reset_cause_flag_b}, 16'h0002);
    chk(ctx_acc, 16'h0000);
    fire(STEP, 10'h000, 8'h00, 8'h00);
    chk(fetch_addr, 16'h0001);
    fire(JMP, 10'h123, 8'h00, 8'h00);
    fire(IRQ, 10'h000, 8'h00, 8'h00);
    chk(fetch_addr, 16'h0008);
    chk({push_valid, push_addr}, 16'h0523);
    fire(RET, 10'h3FD, 8'h00, 8'h00);
    chk({pc_in_reserved, fetch_addr}, 16'h07FD);
    fire(JMP, 10'h0FF, 8'h00, 8'h00);
    fire(ADD, 10'h000, 8'h01, 8'h00);
    chk(fetch_addr, 16'h0100);
    fire(SUB, 10'h000, 8'h01, 8'h00);
    chk(fetch_addr, 16'h01FF);
    fire(SAV, 10'h000, 8'hAA, 8'hFF);
    chk({ctx_flags, ctx_acc}, 16'h3FAA);
    fire(SAV, 10'h000, 8'h55, 8'hC1);
    chk({ctx_flags, ctx_acc}, 16'h0155);
    fire(RES, 10'h000, 8'h00, 8'h00);
    chk(ctx_restore_valid, 16'h0001);
    fire(HWR, 10'h000, 8'h12, 8'h00);
    fire(LWR, 10'h000, 8'hFF, 8'h00);
    fire(LINC, 10'h000, 8'h00, 8'h00);
    chk({idx_high, idx_low}, 16'h1200);
    fire(TRD, 10'h000, 8'h00, 8'h00);
    chk(rom_addr, 16'h1200);
    chk(rom_rd_en, 16'h0001);
    chk(tbl_busy, 16'h0001);
    // Second start while busy must be ignored
    fire(TRD, 10'h000, 8'h00, 8'h00);
    n = 0;
    while (tbl_done !== 1'b1 && n < 8)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 8)
    begin
      err_count++;
      report_and_stop();
    end
    chk({lookup_result, tbl_acc_data}, 16'h5105);
    chk(tbl_busy, 16'h0000);
    fire(HINC, 10'h000, 8'h00, 8'h00);
    chk({idx_high, idx_low}, 16'h1300);
    fire(EXT, 10'h000, 8'h00, 8'h00);
    repeat (2) @(negedge clk_sys);
    chk({reset_cause_flag_a, reset_cause_flag_b}, 16'h0003);
    chk(fetch_addr, 16'h0000);
    chk({idx_high, idx_low}, 16'h0000);
    chk({ctx_flags, ctx_acc}, 16'h0000);
    chk({lookup_result, tbl_acc_data}, 16'h0000);
    // Jump placed at the reset entry point
    fire(JMP, 10'h200, 8'h00, 8'h00);
    chk(fetch_addr, 16'h0200);
    fire(WDT, 10'h000, 8'h00, 8'h00);
    repeat (2) @(negedge clk_sys);
    chk({reset_cause_flag_a, reset_cause_flag_b, fetch_addr}, 16'h0000);
    fire(JMP, 10'h155, 8'h00, 8'h00);
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({reset_cause_flag_a, reset_cause_flag_b}, 16'h0002);
    chk(fetch_addr, 16'h0000);
    report_and_stop();
  end
endmodule

`default_nettype wire
